// ==== rtl/imsel_pin_mux.sv ====
// Interface mode select and shared pin multiplexer, top level.
// Assumes peripheral engines on one side and pad cells on the other;
// every pad is split into input, output and active-low output enable.
`timescale 1ns/1ps
`include "imsel_defs.svh"

module imsel_pin_mux (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Mode straps
	input wire logic modeSel0,
	input wire logic modeSel1,
	input wire logic modeSel2,
	// Shared pins, enable low while driving
	input wire logic [6:0] sharedIoIn,
	output logic [6:0] sharedIoOut,
	output logic [6:0] sharedIoOeN,
	// General I/O engine
	input wire logic [6:0] gpioOut,
	input wire logic [6:0] gpioDir,
	output logic [6:0] gpioIn,
	// UART engine
	input wire logic uartTxd,
	input wire logic uartRtsN,
	input wire logic uartTxActive,
	output logic uartRxd,
	output logic uartCtsN,
	// PWM engine
	input wire logic [3:0] pwmOut,
	// I2C master engine, open drain: high requests pulling low
	input wire logic i2cSclPullLow,
	input wire logic i2cSdaPullLow,
	output logic i2cSclIn,
	output logic i2cSdaIn,
	// SPI slave engine
	input wire logic spiSlvMiso,
	input wire logic spiSlvMisoEn,
	output logic targetSelectInN,
	output logic spiSlvClk,
	output logic spiSlvMosi,
	// SPI master engine
	input wire logic controllerSelectOutN,
	input wire logic spiMstClk,
	input wire logic spiMstMosi,
	output logic spiMstMiso,
	// USB side
	input wire logic vbusPowerReq,
	input wire logic usbFault,
	output logic vbusPowerEnN,
	output logic usbErrorN,
	// Status
	output imsel_pkg::imsel_mode_t activeMode,
	output logic modeReady,
	output logic testStrapSeen
);

	imsel_pkg::imsel_mode_t mode;
	logic captured;
	logic testStrap;

	// Strap capture, held until the next reset
	imsel_mode_latch u_latch (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.modeSel0(modeSel0),
		.modeSel1(modeSel1),
		.modeSel2(modeSel2),
		.mode_q(mode),
		.captured_q(captured),
		.testStrap_q(testStrap)
	);

	// One-hot personality selects; IDLE enables none of them
	logic isGpio;
	logic isUart;
	logic isPwm;
	logic isI2c;
	logic isSpis;
	logic isSpim;
	assign isGpio = (mode == imsel_pkg::MODE_GPIO);
	assign isUart = (mode == imsel_pkg::MODE_UART);
	assign isPwm = (mode == imsel_pkg::MODE_PWM);
	assign isI2c = (mode == imsel_pkg::MODE_I2C);
	assign isSpis = (mode == imsel_pkg::MODE_SPIS);
	assign isSpim = (mode == imsel_pkg::MODE_SPIM);

	// Per-mode pin drive values and enables (enable high = drive here)
	logic [6:0] uartDrv;
	logic [6:0] uartEn;
	logic [6:0] i2cEn;
	logic [6:0] spisEn;
	logic [6:0] spimDrv;
	logic [6:0] spimEn;
	assign uartDrv = {2'h0, uartTxActive, 1'h0, uartRtsN, 1'h0, uartTxd};
	assign uartEn = 7'h15;
	assign i2cEn = {5'h00, i2cSdaPullLow, i2cSclPullLow};
	assign spisEn = {spiSlvMisoEn, 6'h00};
	assign spimDrv = {1'h0, spiMstMosi, spiMstClk, controllerSelectOutN, 3'h0};
	assign spimEn = 7'h38;

	// Pin selection, only the decoded mode steers it
	logic [6:0] sharedIoOut_d;
	logic [6:0] pinEn;
	logic [6:0] sharedIoOeN_d;
	assign sharedIoOut_d = isGpio ? gpioOut :
		isUart ? uartDrv :
		isPwm ? {3'h0, pwmOut} :
		isSpis ? {spiSlvMiso, 6'h00} :
		isSpim ? spimDrv :
		7'h00; // I2C drives zero only
	// Pins with no function in the mode stay inputs
	assign pinEn = isGpio ? gpioDir :
		isUart ? uartEn :
		isPwm ? 7'h0F :
		isI2c ? i2cEn :
		isSpis ? spisEn :
		isSpim ? spimEn :
		7'h00;
	// Pad enables are active low; a cleared enable bit floats the pin
	assign sharedIoOeN_d = ~pinEn;

	// Pad outputs are registered so they never glitch on a mode edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sharedIoOut <= `IMSEL_RST_PIN_OUT;
			sharedIoOeN <= `IMSEL_RST_PIN_OEN;
		end else if (clkEn) begin
			sharedIoOut <= sharedIoOut_d;
			sharedIoOeN <= sharedIoOeN_d;
		end
	end

	// Inputs returned to engines; unselected engines see their idle level
	// GPIO mode hands back every pin level, also on pins that it drives
	logic [6:0] gpioIn_d;
	assign gpioIn_d = isGpio ? sharedIoIn : `IMSEL_RST_GPIO_IN;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gpioIn <= `IMSEL_RST_GPIO_IN;
		end else if (clkEn) begin
			gpioIn <= gpioIn_d;
		end
	end

	// Serial return paths. An engine that is not selected sees its idle
	// level, so a stray pin level cannot fake a start bit or a clock edge.
	// UART and I2C lines idle high, SPI clock and data idle low.
	logic uartRxd_d;
	logic uartCtsN_d;
	logic i2cSclIn_d;
	logic i2cSdaIn_d;
	logic targetSelectInN_d;
	logic spiSlvClk_d;
	logic spiSlvMosi_d;
	logic spiMstMiso_d;
	assign uartRxd_d = isUart ? sharedIoIn[`IMSEL_POS_UART_RXD] : 1'h1;
	assign uartCtsN_d = isUart ? sharedIoIn[`IMSEL_POS_UART_CTS] : 1'h1;
	assign i2cSclIn_d = isI2c ? sharedIoIn[`IMSEL_POS_I2C_SCL] : 1'h1;
	assign i2cSdaIn_d = isI2c ? sharedIoIn[`IMSEL_POS_I2C_SDA] : 1'h1;
	assign targetSelectInN_d = isSpis ? sharedIoIn[`IMSEL_POS_SPI_SEL] : 1'h1;
	assign spiSlvClk_d = isSpis ? sharedIoIn[`IMSEL_POS_SPI_CLK] : 1'h0;
	assign spiSlvMosi_d = isSpis ? sharedIoIn[`IMSEL_POS_SPI_MOSI] : 1'h0;
	assign spiMstMiso_d = isSpim ? sharedIoIn[`IMSEL_POS_SPI_MISO] : 1'h0;

	// UART and I2C receive registers, idle high when not selected
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			uartRxd <= `IMSEL_RST_IDLE_HIGH;
			uartCtsN <= `IMSEL_RST_IDLE_HIGH;
			i2cSclIn <= `IMSEL_RST_IDLE_HIGH;
			i2cSdaIn <= `IMSEL_RST_IDLE_HIGH;
		end else if (clkEn) begin
			uartRxd <= uartRxd_d;
			uartCtsN <= uartCtsN_d;
			i2cSclIn <= i2cSclIn_d;
			i2cSdaIn <= i2cSdaIn_d;
		end
	end

	// SPI receive registers; select idles deasserted, clock idles low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			targetSelectInN <= `IMSEL_RST_IDLE_HIGH;
			spiSlvClk <= `IMSEL_RST_IDLE_LOW;
			spiSlvMosi <= `IMSEL_RST_IDLE_LOW;
			spiMstMiso <= `IMSEL_RST_IDLE_LOW;
		end else if (clkEn) begin
			targetSelectInN <= targetSelectInN_d;
			spiSlvClk <= spiSlvClk_d;
			spiSlvMosi <= spiSlvMosi_d;
			spiMstMiso <= spiMstMiso_d;
		end
	end

	// Power switch and error indicator are active low; both off in reset.
	// One register stage only, so a fault shows one cycle after it is seen.
	logic vbusPowerEnN_d;
	logic usbErrorN_d;
	assign vbusPowerEnN_d = ~vbusPowerReq;
	assign usbErrorN_d = ~usbFault;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vbusPowerEnN <= `IMSEL_RST_IDLE_HIGH;
			usbErrorN <= `IMSEL_RST_IDLE_HIGH;
		end else if (clkEn) begin
			vbusPowerEnN <= vbusPowerEnN_d;
			usbErrorN <= usbErrorN_d;
		end
	end

	// Status mirrors; one cycle behind the latch like the pads
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			activeMode <= imsel_pkg::MODE_IDLE;
			modeReady <= 1'h0;
			testStrapSeen <= 1'h0;
		end else if (clkEn) begin
			activeMode <= mode;
			modeReady <= captured;
			testStrapSeen <= testStrap;
		end
	end

endmodule : imsel_pin_mux

// ==== rtl/imsel_defs.svh ====
// Constants for the interface mode select pin multiplexer.
// Assumes inclusion by bare name from the rtl/ folder.
//
// Contract
// - Straps decode: sel2 MSB, eight codes.
// - Open strap reads one, grounded reads zero.
// - Code 111 behaves as general I/O.
// - Pin function depends only on mode.
// - Fixed pin map for each personality.
// - Exactly six personalities, one active.
// - Low reset input holds logic reset.
// - Drive VBUS enable low for power.
// - Assert low error on USB problem.
// - Only one interface active, strap chosen.
`ifndef IMSEL_DEFS_SVH
`define IMSEL_DEFS_SVH

// Pin count and strap codes, sel2 is the top bit
`define IMSEL_PIN_COUNT 7
`define IMSEL_CODE_GPIO 3'h0
`define IMSEL_CODE_UART 3'h1
`define IMSEL_CODE_PWM 3'h2
`define IMSEL_CODE_I2C 3'h3
`define IMSEL_CODE_SPIS 3'h4
`define IMSEL_CODE_SPIM 3'h5
`define IMSEL_CODE_TEST 3'h6
`define IMSEL_CODE_ALTGPIO 3'h7

// Pin positions of each function
`define IMSEL_POS_UART_TXD 0
`define IMSEL_POS_UART_RXD 1
`define IMSEL_POS_UART_RTS 2
`define IMSEL_POS_UART_CTS 3
`define IMSEL_POS_UART_TXACT 4
`define IMSEL_POS_I2C_SCL 0
`define IMSEL_POS_I2C_SDA 1
`define IMSEL_POS_SPI_SEL 3
`define IMSEL_POS_SPI_CLK 4
`define IMSEL_POS_SPI_MOSI 5
`define IMSEL_POS_SPI_MISO 6

// Reset values of registered outputs
`define IMSEL_RST_PIN_OUT 7'h00
`define IMSEL_RST_PIN_OEN 7'h7F
`define IMSEL_RST_GPIO_IN 7'h00
`define IMSEL_RST_IDLE_HIGH 1'h1
`define IMSEL_RST_IDLE_LOW 1'h0

`endif

// ==== rtl/imsel_pkg.sv ====
// Types and strap decode for the interface mode select pin multiplexer.
// Assumes imsel_defs.svh is on the include path.
`include "imsel_defs.svh"

package imsel_pkg;

	// Personality in force; IDLE before capture and for the test code
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_GPIO,
		MODE_UART,
		MODE_PWM,
		MODE_I2C,
		MODE_SPIS,
		MODE_SPIM
	} imsel_mode_t;

	// Strap code to personality
	function automatic imsel_mode_t imsel_decode(input logic [2:0] code);
		imsel_mode_t m;
		m = MODE_IDLE;
		unique case (code)
			`IMSEL_CODE_GPIO: m = MODE_GPIO;
			`IMSEL_CODE_UART: m = MODE_UART;
			`IMSEL_CODE_PWM: m = MODE_PWM;
			`IMSEL_CODE_I2C: m = MODE_I2C;
			`IMSEL_CODE_SPIS: m = MODE_SPIS;
			`IMSEL_CODE_SPIM: m = MODE_SPIM;
			`IMSEL_CODE_TEST: m = MODE_IDLE;
			`IMSEL_CODE_ALTGPIO: m = MODE_GPIO;
		endcase
		return m;
	endfunction : imsel_decode

endpackage : imsel_pkg

// ==== rtl/imsel_mode_latch.sv ====
// Captures the mode straps once after reset release and holds the mode.
// Assumes strap pads resolve an open strap to one through their pull-up.
`timescale 1ns/1ps
`include "imsel_defs.svh"

module imsel_mode_latch (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Strap levels
	input wire logic modeSel0,
	input wire logic modeSel1,
	input wire logic modeSel2,
	// Captured mode
	output imsel_pkg::imsel_mode_t mode_q,
	output logic captured_q,
	output logic testStrap_q
);

	logic [2:0] strapCode;

	// sel2 is the most significant bit
	assign strapCode = {modeSel2, modeSel1, modeSel0};

	// Caught on the first enabled edge after release, so the async reset
	// only ever loads constants; afterwards strap changes are ignored
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= imsel_pkg::MODE_IDLE;
			captured_q <= 1'h0;
			testStrap_q <= 1'h0;
		end else if (clkEn && !captured_q) begin
			mode_q <= imsel_pkg::imsel_decode(strapCode);
			captured_q <= 1'h1;
			testStrap_q <= (strapCode == `IMSEL_CODE_TEST);
		end
	end

endmodule : imsel_mode_latch

// ==== sim/imsel_pin_mux_props.sv ====
// Port checker for the pin multiplexer.
// Assumes a bind onto imsel_pin_mux, one clock domain.
`timescale 1ns/1ps

module imsel_pin_mux_props (
	// Clock and control
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Watched ports
	input wire logic vbusPowerReq,
	input wire logic usbFault,
	input wire logic [3:0] pwmOut,
	input wire logic vbusPowerEnN,
	input wire logic usbErrorN,
	input wire logic [6:0] sharedIoOut,
	input wire logic [6:0] sharedIoOeN,
	input imsel_pkg::imsel_mode_t activeMode,
	input wire logic modeReady,
	input wire logic testStrapSeen
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Past terms skip the edge that still saw reset
	chk_vbus_invert: assert property (
		$past(resetn) && $past(clkEn) |-> vbusPowerEnN == !$past(vbusPowerReq))
		else $error("vbus enable not inverted request");
	chk_error_invert: assert property (
		$past(resetn) && $past(clkEn) |-> usbErrorN == !$past(usbFault))
		else $error("usb error not inverted fault");
	chk_mode_held: assert property (
		$past(modeReady) && modeReady |-> $stable(activeMode))
		else $error("mode moved after capture");
	chk_ready_time: assert property (
		$rose(resetn) && clkEn ##1 clkEn [*2] |-> modeReady)
		else $error("mode not ready in time");
	chk_idle_inputs: assert property (
		!modeReady |-> sharedIoOeN == 7'h7F)
		else $error("pin driven before capture");
	chk_test_idle: assert property (
		testStrapSeen |-> activeMode == imsel_pkg::MODE_IDLE && sharedIoOeN == 7'h7F)
		else $error("test code not idle");
	chk_pwm_dirs: assert property (
		activeMode == imsel_pkg::MODE_PWM |-> sharedIoOeN == 7'h70)
		else $error("pwm directions wrong");
	chk_pwm_map: assert property (
		activeMode == imsel_pkg::MODE_PWM && $past(modeReady) && $past(clkEn)
		|-> sharedIoOut[3:0] == $past(pwmOut))
		else $error("pwm channel not on pin");
endmodule : imsel_pin_mux_props

bind imsel_pin_mux imsel_pin_mux_props u_props (.core_clk(core_clk), .resetn(resetn),
	.clkEn(clkEn), .vbusPowerReq(vbusPowerReq), .usbFault(usbFault), .pwmOut(pwmOut),
	.vbusPowerEnN(vbusPowerEnN), .usbErrorN(usbErrorN), .sharedIoOut(sharedIoOut),
	.sharedIoOeN(sharedIoOeN), .activeMode(activeMode), .modeReady(modeReady),
	.testStrapSeen(testStrapSeen));

// ==== sim/imsel_board.sv ====
// Board model: strap fitting and far-side devices on the pins.
// Assumes pads split into in, out and active-low enable.
`timescale 1ns/1ps

module imsel_board (
	// Strap fitting, one means left open
	input wire logic [2:0] strapOpen,
	// Far-side devices
	input wire logic [6:0] extDrv,
	input wire logic [6:0] extEn,
	// Pad side of the block
	input wire logic [6:0] sharedIoOut,
	input wire logic [6:0] sharedIoOeN,
	output logic [6:0] sharedIoIn,
	output logic [2:0] modeSel
);
	// Open straps read one through the pull-up
	assign modeSel = strapOpen;
	// Block wins where it drives, else device, else pull-up
	assign sharedIoIn = (~sharedIoOeN & sharedIoOut) | (sharedIoOeN & extEn & extDrv)
		| (sharedIoOeN & ~extEn);
endmodule : imsel_board

// ==== sim/test_interface_mode_select_pin_mux.sv ====
// Testbench: every strap code, pin map, hold, USB pins.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps

module test_interface_mode_select_pin_mux;
	logic core_clk = 1'h0, resetn = 1'h0, clkEn = 1'h1, vbusPowerReq = 1'h0, usbFault = 1'h0;
	logic [6:0] gpioOut = 7'h33, gpioDir = 7'h55, extDrv = 7'h70, extEn = 7'h7F;
	logic uartTxd = 1'h1, uartRtsN = 1'h0, uartTxActive = 1'h1, i2cSclPullLow = 1'h1;
	logic i2cSdaPullLow = 1'h0, spiSlvMiso = 1'h1, spiSlvMisoEn = 1'h1;
	logic controllerSelectOutN = 1'h0, spiMstClk = 1'h1, spiMstMosi = 1'h1;
	logic [3:0] pwmOut = 4'hA;
	logic [2:0] strap = 3'h0, modeSel;
	logic [6:0] sharedIoIn, sharedIoOut, sharedIoOeN, gpioIn;
	logic uartRxd, uartCtsN, i2cSclIn, i2cSdaIn, targetSelectInN, spiSlvClk, spiSlvMosi;
	logic spiMstMiso, vbusPowerEnN, usbErrorN, modeReady, testStrapSeen;
	imsel_pkg::imsel_mode_t activeMode;
	int failCount = 0, checked = 0;
	// Expected per strap code, from the engine levels above
	imsel_pkg::imsel_mode_t expMode [8] = '{imsel_pkg::MODE_GPIO, imsel_pkg::MODE_UART,
		imsel_pkg::MODE_PWM, imsel_pkg::MODE_I2C, imsel_pkg::MODE_SPIS,
		imsel_pkg::MODE_SPIM, imsel_pkg::MODE_IDLE, imsel_pkg::MODE_GPIO};
	logic [6:0] expOeN [8] = '{7'h2A, 7'h6A, 7'h70, 7'h7E, 7'h3F, 7'h47, 7'h7F, 7'h2A};
	logic [6:0] expOut [8] = '{7'h11, 7'h11, 7'h0A, 7'h00, 7'h40, 7'h30, 7'h00, 7'h11};
	logic [6:0] expGpio [8] = '{7'h31, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h31};
	logic [3:0] expRet [8] = '{4'hE, 4'h6, 4'hE, 4'hA, 4'hC, 4'hF, 4'hE, 4'hE};
	// Second set: cts, scl in, slave clock, slave data
	logic [3:0] expRetB [8] = '{4'hC, 4'h4, 4'hC, 4'h8, 4'hF, 4'hC, 4'hC, 4'hC};

	imsel_board board (.strapOpen(strap), .extDrv(extDrv), .extEn(extEn),
		.sharedIoOut(sharedIoOut), .sharedIoOeN(sharedIoOeN), .sharedIoIn(sharedIoIn),
		.modeSel(modeSel));
	imsel_pin_mux dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.modeSel0(modeSel[0]), .modeSel1(modeSel[1]), .modeSel2(modeSel[2]),
		.sharedIoIn(sharedIoIn), .sharedIoOut(sharedIoOut), .sharedIoOeN(sharedIoOeN),
		.gpioOut(gpioOut), .gpioDir(gpioDir), .gpioIn(gpioIn), .uartTxd(uartTxd),
		.uartRtsN(uartRtsN), .uartTxActive(uartTxActive), .uartRxd(uartRxd),
		.uartCtsN(uartCtsN), .pwmOut(pwmOut), .i2cSclPullLow(i2cSclPullLow),
		.i2cSdaPullLow(i2cSdaPullLow), .i2cSclIn(i2cSclIn), .i2cSdaIn(i2cSdaIn),
		.spiSlvMiso(spiSlvMiso), .spiSlvMisoEn(spiSlvMisoEn),
		.targetSelectInN(targetSelectInN), .spiSlvClk(spiSlvClk), .spiSlvMosi(spiSlvMosi),
		.controllerSelectOutN(controllerSelectOutN), .spiMstClk(spiMstClk),
		.spiMstMosi(spiMstMosi), .spiMstMiso(spiMstMiso), .vbusPowerReq(vbusPowerReq),
		.usbFault(usbFault), .vbusPowerEnN(vbusPowerEnN), .usbErrorN(usbErrorN),
		.activeMode(activeMode), .modeReady(modeReady), .testStrapSeen(testStrapSeen));

	// Free-running clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic check_bits(input string what, input logic [6:0] exp, input logic [6:0] got);
		checked++;
		if (got !== exp) begin
			failCount++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_bits

	task automatic check_mode(input string what, input imsel_pkg::imsel_mode_t exp,
		input imsel_pkg::imsel_mode_t got);
		checked++;
		if (got !== exp) begin
			failCount++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_mode

	// Reset with straps fitted, then wait past capture
	task automatic start(input logic [2:0] code);
		resetn = 1'h0;
		strap = code;
		repeat (4) @(posedge core_clk);
		check_bits("reset oe", 7'h7F, sharedIoOeN);
		#1 resetn = 1'h1;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : start

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	// Every strap code, then USB pins and a live PWM change
	initial begin
		for (int c = 0; c < 8; c++) begin
			start(c[2:0]);
			check_mode("mode", expMode[c], activeMode);
			check_bits("pad oe", expOeN[c], sharedIoOeN);
			check_bits("pad out", expOut[c], sharedIoOut & ~expOeN[c]);
			check_bits("gpio in", expGpio[c], gpioIn);
			check_bits("returns", {3'h0, expRet[c]},
				{3'h0, uartRxd, i2cSdaIn, targetSelectInN, spiMstMiso});
			check_bits("returns b", {3'h0, expRetB[c]},
				{3'h0, uartCtsN, i2cSclIn, spiSlvClk, spiSlvMosi});
			check_bits("test flag", {6'h0, c == 6}, {6'h0, testStrapSeen});
			strap = ~strap;
			repeat (2) @(posedge core_clk);
			#1;
			check_mode("held", expMode[c], activeMode);
		end
		start(3'h2);
		pwmOut = 4'h5;
		vbusPowerReq = 1'h1;
		usbFault = 1'h1;
		repeat (2) @(posedge core_clk);
		#1;
		check_bits("pwm", 7'h05, sharedIoOut & 7'h0F);
		check_bits("vbus en", 7'h00, {6'h0, vbusPowerEnN});
		check_bits("usb error", 7'h00, {6'h0, usbErrorN});
		// Enable low must freeze the PWM pins and the VBUS enable, then release it again
		clkEn = 1'h0;
		vbusPowerReq = 1'h0;
		usbFault = 1'h0;
		pwmOut = 4'hA;
		repeat (2) @(posedge core_clk);
		#1;
		check_bits("frozen pwm", 7'h05, sharedIoOut & 7'h0F);
		check_bits("frozen vbus", 7'h00, {6'h0, vbusPowerEnN});
		clkEn = 1'h1;
		repeat (2) @(posedge core_clk);
		#1;
		check_bits("vbus off", 7'h01, {6'h0, vbusPowerEnN});
		check_bits("usb ok", 7'h01, {6'h0, usbErrorN});
		check_bits("pwm back", 7'h0A, sharedIoOut & 7'h0F);
		finish_test();
	end

	// Hang guard, far beyond the run length
	initial begin
		#5000;
		failCount++;
		finish_test();
	end
endmodule : test_interface_mode_select_pin_mux
